// file: i2c_mem_pkg.sv
// Constants and types shared by the two-wire serial memory slave.
package i2c_mem_pkg;

    // ------------------------------------------------------------------
    // Memory geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int MEM_DEPTH = 32768;
    localparam logic [14:0] ADDR_RESET = 15'h0000;
    localparam logic [14:0] ADDR_LAST = 15'h7FFF;
    localparam logic [14:0] ADDR_STEP = 15'h0001;

    // ------------------------------------------------------------------
    // Address word layout and serial unit
    // ------------------------------------------------------------------
    localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int SEL_MSB = 3;
    localparam int SEL_LSB = 1;
    localparam int DIR_BIT = 0;
    localparam logic DIR_READ = 1'b1;
    localparam logic [3:0] BITS_PER_UNIT = 4'h8;
    localparam logic [3:0] CNT_RESET = 4'h0;
    localparam logic [3:0] CNT_STEP = 4'h1;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        st_idle,
        st_rx,
        st_ack_tx,
        st_tx,
        st_ack_rx
    } link_state_e;

    typedef enum logic [1:0] {
        ph_dev,
        ph_addr_hi,
        ph_addr_lo,
        ph_data
    } rx_phase_e;

endpackage

// file: i2c_serial_memory_slave.sv
// Two-wire serial slave with a 32K x 8 byte memory behind it.

module i2c_serial_memory_slave
    import i2c_mem_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic select_pin_bit0,
    input wire logic select_pin_bit1,
    input wire logic select_pin_bit2,
    input wire logic write_protect,
    output logic busy
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Every pin is asynchronous to clk; two flops each, then a third
    // stage on the two link lines to find their edges.
    logic [5:0] pins_raw;
    logic [5:0] sync1_q;
    logic [5:0] sync1_d;
    logic [5:0] sync2_q;
    logic [5:0] sync2_d;
    logic scl_prev_q;
    logic scl_prev_d;
    logic sda_prev_q;
    logic sda_prev_d;

    assign pins_raw = {write_protect, select_pin_bit2, select_pin_bit1,
                       select_pin_bit0, sda_in, scl};

    always_comb begin
        sync1_d = pins_raw;
        sync2_d = sync1_q;
        scl_prev_d = sync2_q[0];
        sda_prev_d = sync2_q[1];
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_q <= 6'h3F;
            sync2_q <= 6'h3F;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            scl_prev_q <= scl_prev_d;
            sda_prev_q <= sda_prev_d;
        end
    end

    // ------------------------------------------------------------------
    // Bus condition decode
    // ------------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic [2:0] sel_s;
    logic wp_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    always_comb begin
        scl_s = sync2_q[0];
        sda_s = sync2_q[1];
        sel_s = {sync2_q[4], sync2_q[3], sync2_q[2]};
        wp_s = sync2_q[5];
        scl_rise = scl_s & ~scl_prev_q;
        scl_fall = ~scl_s & scl_prev_q;
        start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
        stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    end

    // ------------------------------------------------------------------
    // Memory array
    // ------------------------------------------------------------------
    logic [7:0] mem [0:MEM_DEPTH-1];
    logic mem_we;
    logic [14:0] rd_addr;
    logic [7:0] rd_byte;

    // Wraps at the top of the array so running a write or a read past 7FFF
    // simply walks back to location zero.
    function automatic logic [14:0] next_addr(input logic [14:0] a);
        if (a == ADDR_LAST) begin
            next_addr = ADDR_RESET;
        end else begin
            next_addr = a + ADDR_STEP;
        end
    endfunction

    // ------------------------------------------------------------------
    // Link state
    // ------------------------------------------------------------------
    link_state_e state_q;
    link_state_e state_d;
    rx_phase_e phase_q;
    rx_phase_e phase_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic [14:0] addr_q;
    logic [14:0] addr_d;
    logic rw_q;
    logic rw_d;
    logic ack_q;
    logic ack_d;
    logic oe_q;
    logic oe_d;
    logic busy_q;
    logic busy_d;

    // The byte for the next read unit is looked up one address ahead, in the
    // same clock as the falling edge that starts driving it.
    always_comb begin
        rd_addr = (state_q == st_ack_rx) ? next_addr(addr_q) : addr_q;
        rd_byte = mem[rd_addr];
    end

    always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        tx_d = tx_q;
        addr_d = addr_q;
        rw_d = rw_q;
        ack_d = ack_q;
        oe_d = oe_q;
        mem_we = 1'b0;
        if (stop_det) begin
            // A stop anywhere, even mid-byte, drops back to standby.
            state_d = st_idle;
            oe_d = 1'b0;
        end else if (start_det) begin
            // Repeated start is accepted in any state.
            state_d = st_rx;
            phase_d = ph_dev;
            cnt_d = CNT_RESET;
            oe_d = 1'b0;
        end else begin
            case (state_q)
                st_idle: begin
                    oe_d = 1'b0;
                end
                st_rx: begin
                    if (scl_rise && cnt_q != BITS_PER_UNIT) begin
                        shift_d = {shift_q[6:0], sda_s};
                        cnt_d = cnt_q + CNT_STEP;
                    end else if (scl_fall && cnt_q == BITS_PER_UNIT) begin
                        state_d = st_ack_tx;
                        oe_d = 1'b1;
                        case (phase_q)
                            ph_dev: begin
                                if (shift_q[TYPE_MSB:TYPE_LSB] == DEV_TYPE_CODE
                                    && shift_q[SEL_MSB:SEL_LSB] == sel_s) begin
                                    rw_d = shift_q[DIR_BIT];
                                end else begin
                                    state_d = st_idle;
                                    oe_d = 1'b0;
                                end
                            end
                            ph_addr_hi: begin
                                // The top bit of the high byte is not stored.
                                addr_d = {shift_q[6:0], addr_q[7:0]};
                            end
                            ph_addr_lo: begin
                                addr_d = {addr_q[14:8], shift_q};
                            end
                            default: begin
                                oe_d = 1'b1;
                            end
                        endcase
                    end
                end
                st_ack_tx: begin
                    if (scl_fall) begin
                        cnt_d = CNT_RESET;
                        if (phase_q == ph_dev && rw_q == DIR_READ) begin
                            state_d = st_tx;
                            tx_d = rd_byte;
                            oe_d = ~rd_byte[7];
                        end else begin
                            state_d = st_rx;
                            oe_d = 1'b0;
                            case (phase_q)
                                ph_dev: phase_d = ph_addr_hi;
                                ph_addr_hi: phase_d = ph_addr_lo;
                                ph_addr_lo: phase_d = ph_data;
                                default: begin
                                    mem_we = ~wp_s;
                                    addr_d = next_addr(addr_q);
                                end
                            endcase
                        end
                    end
                end
                st_tx: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + CNT_STEP;
                    end else if (scl_fall) begin
                        if (cnt_q == BITS_PER_UNIT) begin
                            state_d = st_ack_rx;
                            oe_d = 1'b0;
                            cnt_d = CNT_RESET;
                        end else begin
                            tx_d = {tx_q[6:0], 1'b0};
                            oe_d = ~tx_q[6];
                        end
                    end
                end
                st_ack_rx: begin
                    if (scl_rise) begin
                        ack_d = ~sda_s;
                    end else if (scl_fall) begin
                        addr_d = next_addr(addr_q);
                        if (ack_q) begin
                            state_d = st_tx;
                            tx_d = rd_byte;
                            oe_d = ~rd_byte[7];
                        end else begin
                            state_d = st_idle;
                            oe_d = 1'b0;
                        end
                    end
                end
                default: begin
                    state_d = st_idle;
                    oe_d = 1'b0;
                end
            endcase
        end
        busy_d = (state_d != st_idle);
    end

    // The counter gets a fixed reset value even though software must not
    // rely on it before the first addressed access.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= st_idle;
            phase_q <= ph_dev;
            cnt_q <= CNT_RESET;
            shift_q <= BYTE_RESET;
            tx_q <= BYTE_RESET;
            addr_q <= ADDR_RESET;
            rw_q <= 1'b0;
            ack_q <= 1'b0;
            oe_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            addr_q <= addr_d;
            rw_q <= rw_d;
            ack_q <= ack_d;
            oe_q <= oe_d;
            busy_q <= busy_d;
        end
    end

    // ------------------------------------------------------------------
    // Array write port
    // ------------------------------------------------------------------
    // No reset on the array: its contents model nonvolatile cells.
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[addr_q] <= shift_q;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Open drain: the level is always low and only the enable moves.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    assign sda_oe = oe_q;
    assign busy = busy_q;

endmodule // i2c_serial_memory_slave

// file: i2c_slave_checker.sv
// Concurrent checks on the pins of the two-wire memory slave.
module i2c_slave_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Pin checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    AST_PULL_LOW_ONLY: assert property (sda_oe |-> !sda_out)
        else $error("sda driven high");
    AST_RESET_QUIET: assert property ($fell(reset) |-> !sda_oe && !busy)
        else $error("not quiet after reset");
    AST_OE_AFTER_FALL: assert property ($changed(sda_oe) |-> !scl && !$past(scl, 2))
        else $error("sda_oe moved outside scl low");
    AST_OE_STEADY_HIGH: assert property (scl && $past(scl, 3) |-> $stable(sda_oe))
        else $error("sda_oe moved while scl high");
    AST_START_BUSY: assert property (scl && $past(scl) && $fell(sda_in) |-> ##[1:6] busy)
        else $error("start not seen");
    AST_STOP_IDLE: assert property (scl && $past(scl) && $rose(sda_in) |-> ##[1:6] !busy)
        else $error("stop not seen");
    AST_IDLE_RELEASED: assert property (!busy |-> !sda_oe)
        else $error("bus held in standby");
    AST_ACK_STANDS: assert property ($rose(sda_oe) |-> sda_oe [*8])
        else $error("low level too short");
endmodule // i2c_slave_checker

bind i2c_serial_memory_slave i2c_slave_checker chk (.clk(clk), .reset(reset), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy));

// file: i2c_master_model.sv
// Behavioural two-wire bus master that clocks the slave.
module i2c_master_model (
    input wire logic clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Bus master tasks
    // ----------------------------------------------------------------
    // Levels move on falling clk edges a quarter period apart, so setup and hold
    // around every scl edge are five clk cycles, above the three the slave needs.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic start_cond();
        sda_low = 1'b0;
        wait_clk(5);
        scl = 1'b1;
        wait_clk(5);
        sda_low = 1'b1;
        wait_clk(5);
        scl = 1'b0;
        wait_clk(5);
    endtask
    task automatic stop_cond();
        sda_low = 1'b1;
        wait_clk(5);
        scl = 1'b1;
        wait_clk(5);
        sda_low = 1'b0;
        wait_clk(8);
    endtask
    task automatic clock_bit(input logic b, output logic seen);
        sda_low = !b;
        wait_clk(5);
        scl = 1'b1;
        wait_clk(5);
        seen = sda_wire;
        wait_clk(5);
        scl = 1'b0;
        wait_clk(5);
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(d[i], s);
        end
        clock_bit(1'b1, s);
        ack = !s;
    endtask
    task automatic read_byte(input logic give_ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, s);
            d[i] = s;
        end
        clock_bit(!give_ack, s);
    endtask
endmodule // i2c_master_model

// file: i2c_serial_memory_slave_tb_top.sv
// Self-checking bench for the two-wire memory slave.
module i2c_serial_memory_slave_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] OWN_SEL = 3'h6;
    logic clk, reset, scl, sda_low, sda_wire, sda_out, sda_oe, busy, wp;
    logic [2:0] sel;
    int bad_count = 0;
    int checks_done = 0;
    // Open drain with a pull-up: released by both parties the wire reads high.
    assign sda_wire = (sda_oe ? sda_out : 1'b1) & !sda_low;
    i2c_serial_memory_slave DUT (.clk(clk), .reset(reset), .scl(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .select_pin_bit0(sel[0]),
        .select_pin_bit1(sel[1]), .select_pin_bit2(sel[2]), .write_protect(wp), .busy(busy));
    i2c_master_model m (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t ns: %s got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic send(input logic [7:0] d);
        logic k;
        m.send_byte(d, k);
        check({7'h00, k}, 8'h01, "ack");
    endtask
    task automatic stop_op();
        m.stop_cond();
        m.wait_clk(3);
        check({7'h00, busy}, 8'h00, "busy");
    endtask
    task automatic open_at(input logic [14:0] a);
        m.start_cond();
        send({4'hA, OWN_SEL, 1'b0});
        send({1'b0, a[14:8]});
        send(a[7:0]);
    endtask
    task automatic write_at(input logic [14:0] a, input logic [7:0] q[$]);
        open_at(a);
        foreach (q[i]) send(q[i]);
        stop_op();
    endtask
    task automatic read_on(input logic [7:0] q[$]);
        logic [7:0] d;
        send({4'hA, OWN_SEL, 1'b1});
        foreach (q[i]) begin
            m.read_byte(i < q.size() - 1, d);
            check(d, q[i], "read");
        end
        stop_op();
    endtask
    task automatic read_at(input logic [14:0] a, input logic [7:0] q[$]);
        open_at(a);
        m.start_cond();
        read_on(q);
    endtask
    task automatic t_select();
        logic k;
        for (int i = 0; i < 8; i++) begin
            sel = 3'(i);
            m.start_cond();
            m.send_byte({4'hA, OWN_SEL, 1'b0}, k);
            check({7'h00, k}, {7'h00, 3'(i) == OWN_SEL}, "select");
            check({7'h00, busy}, {7'h00, 3'(i) == OWN_SEL}, "standby");
            stop_op();
        end
        sel = OWN_SEL;
        m.start_cond();
        m.send_byte({4'hB, OWN_SEL, 1'b1}, k);
        check({7'h00, k}, 8'h00, "type");
        check({7'h00, busy}, 8'h00, "standby");
        stop_op();
        $display("done: select");
    endtask
    task automatic t_wrap();
        write_at(15'h0123, '{8'hA5, 8'h3C});
        read_at(15'h0123, '{8'hA5, 8'h3C});
        write_at(15'h7FFF, '{8'h11, 8'h22, 8'h33});
        read_at(15'h7FFF, '{8'h11, 8'h22});
        m.start_cond();
        read_on('{8'h33});
        $display("done: write and wrap");
    endtask
    task automatic t_protect_abort();
        logic k;
        wp = 1'b1;
        write_at(15'h0123, '{8'hFF, 8'hFF});
        read_at(15'h0123, '{8'hA5, 8'h3C});
        wp = 1'b0;
        open_at(15'h0124);
        for (int i = 0; i < 4; i++) begin
            m.clock_bit(1'b0, k);
        end
        stop_op();
        read_at(15'h0124, '{8'h3C});
        $display("done: protect and abort");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        reset = 1'b1;
        wp = 1'b0;
        sel = OWN_SEL;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        t_select();
        t_wrap();
        t_protect_abort();
        complete_run();
    end
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        $display("ERROR %0t ns: run limit reached", $time);
        complete_run();
    end
endmodule // i2c_serial_memory_slave_tb_top
